// *** sim/bmsq_i2c_host.sv ***
// Purpose: Bus controller model on the link side
// Assumes: Wire level resolved by the bench with a pull-up
// Notes:   Clock stands high between frames, 6 ns per bit
`timescale 1ns/10ps
module bmsq_i2c_host (
	output logic	scl,
	output logic	pull_low,
	input wire logic	sda
);
	// Idle bus: both lines released
	initial begin
		scl = 1'b1;
		pull_low = 1'b0;
	end
	// Data changes only while the clock is low
	task automatic bitx(input logic b, output logic r);
		scl = 1'b0;
		#1 pull_low = ~b;
		#2 scl = 1'b1;
		#1 r = sda;
		#2;
	endtask
	// Falling data with clock high
	task automatic start;
		scl = 1'b0;
		#1 pull_low = 1'b0;
		#2 scl = 1'b1;
		#3 pull_low = 1'b1;
		#3;
	endtask
	// Rising data with clock high, also after an abandoned frame
	task automatic stop;
		scl = 1'b0;
		#1 pull_low = 1'b1;
		#2 scl = 1'b1;
		#3 pull_low = 1'b0;
		#3;
	endtask
	// Eight bits MSB first then the acknowledge slot
	task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
		bitx(a, ack);
	endtask
endmodule // bmsq_i2c_host

// *** sim/bmsq_sequencer_assertions.sv ***
// Purpose: Port-level checks of the mode sequencer
// Assumes: Four clocks cover the two-flop input synchronisers
// Notes:   All checks sample on the system clock
`timescale 1ns/10ps
module bmsq_sequencer_assertions
	import bmsq_pkg::*;
#(
	parameter int unsigned WAKE_HOLD = WAKE_HOLD_CYC // Kept only to match the design
) (
	input wire logic	clk,
	input wire logic	rstn,
	input wire logic	scl_clk,
	input wire logic	sda_i,
	input wire logic	sda_o,
	input wire logic	sda_oe,
	input wire bmsq_supply_t supply,
	input wire logic	pushbutton_n,
	input wire logic	low_power_select_n,
	input wire logic	watchdog_expired,
	input wire logic	irq_pending,
	input wire logic	battery_switch_on,
	input wire logic	output_switch_enable,
	input wire logic	osc_enable,
	input wire logic [1:0]	mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	ship_off_a: assert property (mode == BMSQ_SHIP |-> !battery_switch_on && !output_switch_enable)
		else $error("ship mode left a switch on");
	bat_sw_a: assert property (mode != BMSQ_SHIP |-> battery_switch_on)
		else $error("battery switch off outside ship");
	osc_run_a: assert property (mode inside {BMSQ_ADAPTER, BMSQ_ACTIVE_BAT} |-> osc_enable)
		else $error("oscillator stopped while active");
	osc_stop_a: assert property (mode == BMSQ_LOW_POWER |-> !osc_enable)
		else $error("oscillator runs in low power");
	lp_hold_a: assert property (mode == BMSQ_LOW_POWER && $past(mode) == BMSQ_LOW_POWER
		|-> $stable(output_switch_enable)) else $error("output switch moved in low power");
	lp_block_a: assert property ((supply.in_valid || supply.in_overvolt || !pushbutton_n
		|| low_power_select_n)[*4] |-> mode != BMSQ_LOW_POWER) else $error("bad low power");
	adapter_a: assert property ((supply.in_valid && !supply.in_overvolt)[*4]
		|-> mode == BMSQ_ADAPTER) else $error("valid input without adapter mode");
	ship_stay_a: assert property ((mode == BMSQ_SHIP && !supply.in_valid && !supply.bat_above_max)[*4]
		|=> mode == BMSQ_SHIP) else $error("ship left with a weak battery");
	ack_low_a: assert property (sda_oe |-> !sda_o)
		else $error("data line driven high");
endmodule // bmsq_sequencer_assertions

bind bmsq_sequencer bmsq_sequencer_assertions #(.WAKE_HOLD(WAKE_HOLD)) i_chk (
	.clk(clk), .rstn(rstn), .scl_clk(scl_clk), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe), .supply(supply), .pushbutton_n(pushbutton_n),
	.low_power_select_n(low_power_select_n), .watchdog_expired(watchdog_expired),
	.irq_pending(irq_pending), .battery_switch_on(battery_switch_on),
	.output_switch_enable(output_switch_enable), .osc_enable(osc_enable), .mode(mode));

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the mode sequencer
// Assumes: Short wake hold keeps button presses brief
// Notes:   Low power is tried before any link traffic
`timescale 1ns/10ps
module testbench;
	import bmsq_pkg::*;
	localparam int unsigned HOLD = 20; // Shortened wake hold
	logic	clk, rstn, scl, host_low, sda_o, sda_oe, a;
	logic	btn_n, sel_n, wdog, irq, bsw, osw, osc;
	logic [1:0]	mode;
	logic [7:0]	q;
	bmsq_supply_t	sup;
	int	miscompares = 0;
	int	cmp_count = 0;
	wire logic	sda = ~(host_low | sda_oe); // Pull-up wins when nobody pulls

	bmsq_sequencer #(.WAKE_HOLD(HOLD)) i_bmsq_sequencer (
		.clk(clk), .rstn(rstn), .scl_clk(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.supply(sup), .pushbutton_n(btn_n), .low_power_select_n(sel_n),
		.watchdog_expired(wdog), .irq_pending(irq), .battery_switch_on(bsw),
		.output_switch_enable(osw), .osc_enable(osc), .mode(mode));
	bmsq_i2c_host i_bmsq_i2c_host (.scl(scl), .pull_low(host_low), .sda(sda));

	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report;
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Inputs move 1 ns after the edge
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Bounded wait; running out ends the run
	task automatic wait_mode(input bmsq_mode_t m);
		int n = 0;
		while (mode !== m && n < 400) begin
			hold(1);
			n++;
		end
		chk("mode", {6'h00, m}, {6'h00, mode});
		if (n == 400) final_report;
	endtask
	// Reads compare data, writes compare the acknowledge
	task automatic xfer(input logic [7:0] d, input logic rel, input logic [7:0] exp);
		i_bmsq_i2c_host.xbyte(d, rel, q, a);
		chk(d == 8'hff ? "rdata" : "ack", exp, d == 8'hff ? q : {7'h00, a});
	endtask
	task automatic wr(input logic [7:0] r, input logic [7:0] v);
		i_bmsq_i2c_host.start;
		xfer({TARGET_ADDR, 1'b0}, 1'b1, 8'h00);
		xfer(r, 1'b1, 8'h00);
		xfer(v, 1'b1, 8'h00);
		i_bmsq_i2c_host.stop;
		hold(5);
	endtask
	task automatic rd(input logic [7:0] r, input logic [7:0] e0, input logic [7:0] e1);
		i_bmsq_i2c_host.start;
		xfer({TARGET_ADDR, 1'b0}, 1'b1, 8'h00);
		xfer(r, 1'b1, 8'h00);
		i_bmsq_i2c_host.start;
		xfer({TARGET_ADDR, 1'b1}, 1'b1, 8'h00);
		xfer(8'hff, 1'b0, e0);
		xfer(8'hff, 1'b1, e1);
		i_bmsq_i2c_host.stop;
		hold(5);
	endtask

	task automatic t_lowpower;
		sup.in_valid = 1'b0;
		wait_mode(BMSQ_ACTIVE_BAT);
		irq = 1'b1;
		sel_n = 1'b0;
		hold(50);
		wait_mode(BMSQ_ACTIVE_BAT);
		irq = 1'b0;
		wait_mode(BMSQ_LOW_POWER);
		chk("osc_sw", 8'h01, {6'h00, osc, osw});
		btn_n = 1'b0;
		wait_mode(BMSQ_ACTIVE_BAT);
		btn_n = 1'b1;
		wait_mode(BMSQ_LOW_POWER);
		sup.in_overvolt = 1'b1;
		wait_mode(BMSQ_ACTIVE_BAT);
		sup.in_overvolt = 1'b0;
		wait_mode(BMSQ_LOW_POWER);
		sel_n = 1'b1;
		wait_mode(BMSQ_ACTIVE_BAT);
		sel_n = 1'b0;
		wait_mode(BMSQ_LOW_POWER);
		sup.in_valid = 1'b1;
		wait_mode(BMSQ_ADAPTER);
		sel_n = 1'b1;
	endtask
	task automatic t_regs;
		rd(CTRL_REG_ADDR, CTRL_RESET, 8'h00);
		i_bmsq_i2c_host.start;
		xfer({TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, 8'h01);
		i_bmsq_i2c_host.stop;
		rd(STAT_REG_ADDR, 8'h00, UNMAPPED_READ);
	endtask
	task automatic t_defer;
		wr(CTRL_REG_ADDR, 8'h03);
		hold(50);
		wait_mode(BMSQ_ADAPTER);
		wr(CTRL_REG_ADDR, 8'h02);
		rd(CTRL_REG_ADDR, 8'h02, 8'h00);
		sup.in_valid = 1'b0;
		hold(50);
		wait_mode(BMSQ_ACTIVE_BAT);
	endtask
	task automatic t_ship;
		sup.in_valid = 1'b1;
		wait_mode(BMSQ_ADAPTER);
		wr(CTRL_REG_ADDR, 8'h03);
		wdog = 1'b1;
		btn_n = 1'b0;
		sup.in_valid = 1'b0;
		hold(50);
		wait_mode(BMSQ_ACTIVE_BAT);
		btn_n = 1'b1;
		wait_mode(BMSQ_SHIP);
		chk("switches", 8'h00, {6'h00, bsw, osw});
	endtask
	task automatic t_wake;
		sup.bat_above_max = 1'b0;
		btn_n = 1'b0;
		hold(HOLD + 10);
		btn_n = 1'b1;
		hold(50);
		wait_mode(BMSQ_SHIP);
		sup.bat_above_max = 1'b1;
		btn_n = 1'b0;
		hold(HOLD + 10);
		btn_n = 1'b1;
		wait_mode(BMSQ_ACTIVE_BAT);
		wdog = 1'b0;
		sup.bat_present = 1'b0;
		hold(20);
		sup.bat_present = 1'b1;
		wait_mode(BMSQ_SHIP);
		sup.in_valid = 1'b1;
		wait_mode(BMSQ_ADAPTER);
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		btn_n = 1'b1;
		sel_n = 1'b1;
		wdog = 1'b0;
		irq = 1'b0;
		sup = bmsq_supply_t'(4'hb);
		hold(6);
		chk("reset", 8'h0f, {3'h0, mode, bsw, osw, osc});
		// Input stays valid across reset, so no button hold is owed
		rstn = 1'b1;
		wait_mode(BMSQ_ADAPTER);
		t_lowpower();
		t_regs();
		t_defer();
		t_ship();
		t_wake();
		final_report();
	end
endmodule // testbench

// *** src/bmsq_pkg.sv ***
// Purpose: Shared constants and types for the battery mode sequencer
// Assumes: 100 MHz system clock, I2C target on a separate link clock
// Notes:   All timing counts derive from named times and the clock rate
package bmsq_pkg;

	localparam int unsigned CLK_MHZ            = 100;   // System clock rate
	localparam logic [6:0]  TARGET_ADDR        = 7'h6b; // Wire byte 0xd6 with write bit
	localparam logic [7:0]  UNMAPPED_READ      = 8'hff; // Answer for absent registers
	localparam int unsigned WAKE_HOLD_US       = 500;   // First wake hold time, microseconds
	localparam int unsigned WAKE_HOLD_CYC      = WAKE_HOLD_US * CLK_MHZ;
	localparam logic [7:0]  CTRL_REG_ADDR      = 8'h00; // Register holding ship request
	localparam logic [7:0]  STAT_REG_ADDR      = 8'h01; // Mode status, read only
	localparam int unsigned SHIP_BIT           = 0;     // Ship request bit position
	localparam int unsigned OUTSW_BIT          = 1;     // Output switch enable position
	localparam logic [7:0]  CTRL_RESET         = 8'h02; // Output switch on after reset

	typedef enum logic [1:0] {
		BMSQ_ADAPTER,
		BMSQ_ACTIVE_BAT,
		BMSQ_LOW_POWER,
		BMSQ_SHIP
	} bmsq_mode_t;

	// Analog comparator results travel together
	typedef struct packed {
		logic in_valid;      // Input above lockout
		logic in_overvolt;   // Input above overvoltage threshold
		logic bat_above_max; // Battery above highest undervoltage setting
		logic bat_present;   // Battery above its lockout
	} bmsq_supply_t;

endpackage

// *** src/bmsq_sequencer.sv ***
// Purpose: Operating mode sequencer with an I2C target port for its control bits
// Assumes: scl/sda arrive as split open-drain signals; link logic runs on scl_clk
// Notes:   Written register bytes cross domains by toggle handshake to the system clock
`timescale 1ns/10ps

module bmsq_sequencer
	import bmsq_pkg::*;
#(
	parameter int unsigned WAKE_HOLD = WAKE_HOLD_CYC // Wake hold in clk cycles
) (
	input  wire logic         clk,
	input  wire logic         rstn,                 // Low when both supplies under lockout
	input  wire logic         scl_clk,              // Link clock, the bus clock line
	input  wire logic         sda_i,
	output logic              sda_o,
	output logic              sda_oe,
	input  wire bmsq_supply_t supply,
	input  wire logic         pushbutton_n,
	input  wire logic         low_power_select_n,
	input  wire logic         watchdog_expired,
	input  wire logic         irq_pending,
	output logic              battery_switch_on,
	output logic              output_switch_enable,
	output logic              osc_enable,
	output logic [1:0]        mode
);

	initial begin
		if (WAKE_HOLD < 1)
			$error("WAKE_HOLD must be at least one cycle");
	end

	// Synchronised pins into the system domain
	bmsq_supply_t sup_s1_ff, sup_ff;
	logic pb_s1_ff, pb_ff, lps_s1_ff, lps_ff, wd_s1_ff, wd_ff;
	logic [7:0] ctrl_ff;              // Control register, read by the link side too
	bmsq_mode_t mode_ff, nxt_mode;    // Operating mode, reported in status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sup_s1_ff <= '0;
			sup_ff    <= '0;
			pb_s1_ff  <= 1'b1;
			pb_ff     <= 1'b1;
			lps_s1_ff <= 1'b1;
			lps_ff    <= 1'b1;
			wd_s1_ff  <= 1'b0;
			wd_ff     <= 1'b0;
		end else begin
			sup_s1_ff <= supply;
			sup_ff    <= sup_s1_ff;
			pb_s1_ff  <= pushbutton_n;
			pb_ff     <= pb_s1_ff;
			lps_s1_ff <= low_power_select_n;
			lps_ff    <= lps_s1_ff;
			wd_s1_ff  <= watchdog_expired;
			wd_ff     <= wd_s1_ff;
		end
	end

	// Link side: bus data sampled on rising clock, driven on falling
	// START/STOP are seen as sda edges while scl is high; the sda edge is the clock there
	logic sta_tgl_ff, sto_tgl_ff;         // Toggle on each START / STOP
	always_ff @(negedge sda_i or negedge rstn) begin
		if (!rstn)
			sta_tgl_ff <= 1'b0;
		else if (scl_clk)
			sta_tgl_ff <= ~sta_tgl_ff;
	end
	always_ff @(posedge sda_i or negedge rstn) begin
		if (!rstn)
			sto_tgl_ff <= 1'b0;
		else if (scl_clk)
			sto_tgl_ff <= ~sto_tgl_ff;
	end

	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_REG, L_WDATA, L_RDATA, L_RACK} bmsq_link_t;
	bmsq_link_t lst_ff;
	logic [3:0] bit_ff;                   // Bit count within byte plus acknowledge
	logic [7:0] sh_ff;                    // Shift register
	logic [7:0] ptr_ff;                   // Register pointer
	logic       sta_seen_ff, sto_seen_ff; // Last START/STOP toggles consumed
	logic       ack_ff;                   // Acknowledge pending on ninth clock
	logic       wr_tgl_ff;                // Toggle per written byte
	logic [7:0] wr_addr_ff, wr_data_ff;   // Held stable until next toggle
	logic [7:0] rd_word;                  // Read data from system domain
	logic [7:0] ctrl_l1_ff, ctrl_lk_ff, stat_l1_ff, stat_lk_ff;

	// Control and status pass as slow levels, two flops each
	always_ff @(posedge scl_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_l1_ff <= CTRL_RESET;
			ctrl_lk_ff <= CTRL_RESET;
			stat_l1_ff <= '0;
			stat_lk_ff <= '0;
		end else begin
			ctrl_l1_ff <= ctrl_ff;
			ctrl_lk_ff <= ctrl_l1_ff;
			stat_l1_ff <= {6'h00, mode_ff};
			stat_lk_ff <= stat_l1_ff;
		end
	end

	always_comb begin
		unique case (ptr_ff)
			CTRL_REG_ADDR: rd_word = ctrl_lk_ff;
			STAT_REG_ADDR: rd_word = stat_lk_ff;
			default:       rd_word = UNMAPPED_READ;
		endcase
	end

	// Receive state machine; same protocol at any bus rate, no timing assumed
	always_ff @(posedge scl_clk or negedge rstn) begin
		if (!rstn) begin
			lst_ff      <= L_IDLE;
			bit_ff      <= '0;
			sh_ff       <= '0;
			ptr_ff      <= '0;
			sta_seen_ff <= 1'b0;
			sto_seen_ff <= 1'b0;
			wr_tgl_ff   <= 1'b0;
			wr_addr_ff  <= '0;
			wr_data_ff  <= '0;
		end else if (sto_tgl_ff != sto_seen_ff) begin
			sto_seen_ff <= sto_tgl_ff;
			sta_seen_ff <= sta_tgl_ff;
			lst_ff      <= (sta_tgl_ff != sta_seen_ff) ? L_ADDR : L_IDLE;
			bit_ff      <= 4'd1;
			sh_ff       <= {7'h00, sda_i};
		end else if (sta_tgl_ff != sta_seen_ff) begin
			// First rising edge after START (or repeated START) carries address bit 7
			sta_seen_ff <= sta_tgl_ff;
			lst_ff      <= L_ADDR;
			bit_ff      <= 4'd1;
			sh_ff       <= {7'h00, sda_i};
		end else begin
			bit_ff <= (bit_ff == 4'd8) ? 4'd0 : bit_ff + 4'd1;
			if (bit_ff != 4'd8)
				sh_ff <= {sh_ff[6:0], sda_i};
			unique case (lst_ff)
				L_IDLE: ;
				L_ADDR: if (bit_ff == 4'd8) begin
					if (sh_ff[7:1] != TARGET_ADDR)
						lst_ff <= L_IDLE;
					else if (sh_ff[0]) begin
						lst_ff <= L_RDATA;
						sh_ff  <= rd_word;
					end else
						lst_ff <= L_REG;
				end
				L_REG: if (bit_ff == 4'd8) begin
					ptr_ff <= sh_ff;
					lst_ff <= L_WDATA;
				end
				L_WDATA: if (bit_ff == 4'd8) begin
					wr_addr_ff <= ptr_ff;
					wr_data_ff <= sh_ff;
					wr_tgl_ff  <= ~wr_tgl_ff;
					ptr_ff     <= ptr_ff + 8'h01;
				end
				L_RDATA: if (bit_ff == 4'd7) begin
					lst_ff <= L_RACK;
					ptr_ff <= ptr_ff + 8'h01;
				end
				L_RACK: if (bit_ff == 4'd8) begin
					// Controller acknowledge low continues; high ends the read
					lst_ff <= sda_i ? L_IDLE : L_RDATA;
					sh_ff  <= rd_word;
					bit_ff <= 4'd0;
				end
				default: lst_ff <= L_IDLE;
			endcase
		end
	end

	// Drive on falling edge so sda only moves while scl is low
	always_ff @(negedge scl_clk or negedge rstn) begin
		if (!rstn) begin
			sda_oe <= 1'b0;
			sda_o  <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			if (bit_ff == 4'd8 && (lst_ff == L_REG || lst_ff == L_WDATA))
				sda_oe <= 1'b1;
			else if (bit_ff == 4'd8 && lst_ff == L_ADDR && sh_ff[7:1] == TARGET_ADDR)
				sda_oe <= 1'b1;
			else if (lst_ff == L_RDATA || (lst_ff == L_RACK && bit_ff == 4'd7))
				sda_oe <= ~sh_ff[7];                                      // Shifted each rise
			else
				sda_oe <= 1'b0;
		end
	end

	// Busy level for the idle check, crossing as a level
	logic link_busy_ff, busy_s1_ff, busy_ff;
	always_ff @(posedge scl_clk or negedge rstn) begin
		if (!rstn)
			link_busy_ff <= 1'b0;
		else
			link_busy_ff <= (lst_ff != L_IDLE);
	end

	// Write toggle and busy into the system domain
	logic wt_s1_ff, wt_s2_ff, wt_s3_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wt_s1_ff   <= 1'b0;
			wt_s2_ff   <= 1'b0;
			wt_s3_ff   <= 1'b0;
			busy_s1_ff <= 1'b0;
			busy_ff    <= 1'b0;
		end else begin
			wt_s1_ff   <= wr_tgl_ff;
			wt_s2_ff   <= wt_s1_ff;
			wt_s3_ff   <= wt_s2_ff;
			busy_s1_ff <= link_busy_ff;
			busy_ff    <= busy_s1_ff;
		end
	end
	wire wr_evt = wt_s2_ff ^ wt_s3_ff;  // Address/data held stable since toggle

	// Control register; kept until both supplies fail, which drives rstn
	logic       ship_done;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			ctrl_ff <= CTRL_RESET;
		else if (wr_evt && wr_addr_ff == CTRL_REG_ADDR && mode_ff != BMSQ_SHIP) begin
			ctrl_ff <= wr_data_ff;
			// A write in the ship entry cycle wins; that entry does not clear the written request
		end else if (ship_done)
			ctrl_ff[SHIP_BIT] <= 1'b0;
		// Watchdog expiry deliberately leaves the request alone
	end

	// Wake hold counter for button presses in ship mode
	logic [$clog2(WAKE_HOLD+1)-1:0] hold_ff;
	logic                           held_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_ff <= '0;
			held_ff <= 1'b0;
		end else if (pb_ff) begin
			hold_ff <= '0;
			// Cleared on release; the release cycle still sees the old flag
			held_ff <= 1'b0;
		end else if (hold_ff != WAKE_HOLD[$clog2(WAKE_HOLD+1)-1:0])
			hold_ff <= hold_ff + 1'b1;
		else
			held_ff <= 1'b1;
	end

	// Mode state machine
	logic       bat_prev_ff;
	always_comb begin
		nxt_mode  = mode_ff;
		ship_done = 1'b0;
		unique case (mode_ff)
			BMSQ_SHIP: begin
				if (sup_ff.in_valid)
					nxt_mode = BMSQ_ADAPTER;
				else if (held_ff && pb_ff && sup_ff.bat_above_max)
					nxt_mode = BMSQ_ACTIVE_BAT;
			end
			default: begin
				// Ship entry ignores charge enable entirely
				if (!sup_ff.in_valid && sup_ff.bat_present && !bat_prev_ff && pb_ff)
					nxt_mode = BMSQ_SHIP;
				else if (ctrl_ff[SHIP_BIT] && !sup_ff.in_valid && pb_ff) begin
					nxt_mode  = BMSQ_SHIP;
					ship_done = 1'b1;
				end else if (sup_ff.in_valid)
					nxt_mode = BMSQ_ADAPTER;
				else if (lps_ff)
					nxt_mode = BMSQ_ACTIVE_BAT;
				else if (sup_ff.in_overvolt || !pb_ff)
					nxt_mode = BMSQ_ACTIVE_BAT;
				else if (!busy_ff && !irq_pending)
					nxt_mode = BMSQ_LOW_POWER;
				else if (mode_ff == BMSQ_ADAPTER)
					nxt_mode = BMSQ_ACTIVE_BAT;
			end
		endcase
	end

	// lps_ff low means low power selected (active low select pin)
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff     <= BMSQ_ACTIVE_BAT;
			bat_prev_ff <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			bat_prev_ff <= sup_ff.bat_present;
		end
	end

	// Outputs from flops; low power holds switch setting, stops oscillator
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			battery_switch_on    <= 1'b1;                                 // Matches reset mode
			output_switch_enable <= CTRL_RESET[OUTSW_BIT];
			osc_enable           <= 1'b1;
			mode                 <= BMSQ_ACTIVE_BAT;
		end else begin
			battery_switch_on <= (nxt_mode != BMSQ_SHIP);
			if (nxt_mode == BMSQ_SHIP)
				output_switch_enable <= 1'b0;
			else if (nxt_mode != BMSQ_LOW_POWER)
				output_switch_enable <= ctrl_ff[OUTSW_BIT];
			osc_enable <= (nxt_mode == BMSQ_ADAPTER || nxt_mode == BMSQ_ACTIVE_BAT);
			mode       <= nxt_mode;
		end
	end

endmodule // bmsq_sequencer
